// [shared/rfbac_pkg.sv]
package rfbac_pkg;
	// command codes
	localparam logic [7:0] RFBAC_CMD_READ_ONE   = 8'h20;
	localparam logic [7:0] RFBAC_CMD_WRITE_ONE  = 8'h21;
	localparam logic [7:0] RFBAC_CMD_READ_MULTI = 8'h23;
	localparam logic [7:0] RFBAC_CMD_SELECT     = 8'h25;
	// error codes
	localparam logic [7:0] RFBAC_ERR_GENERIC    = 8'h0f;
	localparam logic [7:0] RFBAC_ERR_NO_BLOCK   = 8'h10;
	localparam logic [7:0] RFBAC_ERR_LOCKED     = 8'h12;
	localparam logic [7:0] RFBAC_ERR_PROG_FAIL  = 8'h13;
	localparam logic [7:0] RFBAC_ERR_RD_PROT    = 8'h15;
	localparam logic [7:0] RFBAC_ERR_OPTION     = 8'h03;
	// request flag bit positions
	localparam int RFBAC_FLAG_PROT_EXT = 3;
	localparam int RFBAC_FLAG_SELECT   = 4;
	localparam int RFBAC_FLAG_ADDRESS  = 5;
	localparam int RFBAC_FLAG_OPTION   = 6;
	// response flags byte
	localparam logic [7:0] RFBAC_RESP_OK  = 8'h00;
	localparam logic [7:0] RFBAC_RESP_ERR = 8'h01;
	// memory geometry
	localparam logic [15:0] RFBAC_LAST_BLOCK  = 16'h01ff;
	localparam int          RFBAC_SECTOR_LSB  = 5;
	localparam logic [7:0]  RFBAC_MAX_BLK_FLD = 8'h1f;
	// timing
	localparam int RFBAC_CLK_PERIOD_PS      = 4000;
	localparam int RFBAC_NOM_REPLY_DELAY_PS = 320900000;
	localparam int RFBAC_PROG_PERIOD_PS     = 302000000;
	localparam int RFBAC_PROG_PERIODS       = 18;
	localparam longint RFBAC_PROG_TIME_PS   = longint'(RFBAC_NOM_REPLY_DELAY_PS)
		+ longint'(RFBAC_PROG_PERIODS) * longint'(RFBAC_PROG_PERIOD_PS);
	localparam int RFBAC_PROG_CYCLES = int'((RFBAC_PROG_TIME_PS
		+ longint'(RFBAC_CLK_PERIOD_PS) - 64'sd1) / longint'(RFBAC_CLK_PERIOD_PS));
	// response fifo
	localparam int RFBAC_FIFO_WIDTH = 9;
	localparam int RFBAC_FIFO_DEPTH = 16;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_EVAL   = 4'h1,
		ST_CHK    = 4'h2,
		ST_RDREQ  = 4'h3,
		ST_RDWAIT = 4'h4,
		ST_SEC    = 4'h5,
		ST_DATA   = 4'h6,
		ST_PROG   = 4'h7,
		ST_FLAGS  = 4'h8,
		ST_ERRC   = 4'h9,
		ST_DRAIN  = 4'ha
	} rfbac_state_t;
endpackage

// [design/rfbac_edge.sv]
`timescale 1ns/10ps
`default_nettype none
module rfbac_edge (
	input  wire logic sys_clk,  // system clock
	input  wire logic srst,     // synchronous reset
	input  wire logic pin_in,   // asynchronous link clock
	output var  logic rise      // one-cycle pulse per rising edge
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise   <= 1'b0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			rise   <= sync_r & ~prev_r;
		end
	end
endmodule
`default_nettype wire

// [design/rfbac_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module rfbac_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,   // system clock
	input  wire logic             srst,      // synchronous reset
	input  wire logic             in_valid,  // write request
	output var  logic             in_ready,  // space available
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output var  logic             out_valid, // word available
	input  wire logic             out_ready, // read request
	output var  logic [WIDTH-1:0] out_data   // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [AW:0]      cnt_r;
	logic             wr;
	logic             rd;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rptr_r];
	assign wr        = in_valid & in_ready;
	assign rd        = out_valid & out_ready;

	always_ff @(posedge sys_clk) begin
		if (wr) begin
			mem[wptr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
		end else begin
			if (wr) begin
				wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
			end
			if (rd) begin
				rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
			end
			if (wr && !rd) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (rd && !wr) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [design/rfbac_top.sv]
// How it works
// - read-one (20h) fetches the addressed block and returns its 32 data bits
// - read, write and multi-read with protocol extension bit clear answer an error
// - read-one reply: flags, security byte if option set, four data bytes, crc
// - security byte: bit0 lock, bits1-2 read/write protection, bits3-4 password, rest zero
// - read-one errors: 10h missing block, 15h read-protected block
// - busy mode: pin low from request start of frame until reply fully sent
// - write-in-progress mode: pin released during read, multi-read and select
// - write-one (21h) stores 32 data bits into the block and reports outcome
// - write reply only after program cycle: nominal delay plus 18 x 302 us
// - write errors: 0Fh generic, 10h missing, 12h locked, 13h programming failed
// - write-in-progress mode: pin low from valid write end until reply starts
// - multi-read (23h) reads count field plus one consecutive blocks
// - blocks up to 1FFh, at most 32, one sector, else error
// - multi-read reply repeats optional security byte and 32 data bits per block
// - multi-read errors: 0Fh generic, 10h missing, 15h read-protected
// - select (25h) with own uid enters or stays selected and replies
// - select with foreign uid drops a selected tag to ready, silently
// - select errors reply only on own uid and keep the protocol state
// - select error reply is flags plus code; 03h means option unsupported
`timescale 1ns/10ps
`default_nettype none
module rfbac_top
	import rfbac_pkg::*;
#(
	parameter int PROG_CYCLES = RFBAC_PROG_CYCLES
) (
	input  wire logic        sys_clk,       // 250 MHz system clock
	input  wire logic        srst,          // synchronous reset, high
	input  wire logic        rf_clk,        // carrier-derived link clock
	input  wire logic        req_sof,       // request start of frame pulse
	input  wire logic        req_end,       // request decoded pulse, fields valid
	input  wire logic        req_crc_ok,    // crc check passed
	input  wire logic        req_fmt_ok,    // frame format correct
	input  wire logic [7:0]  req_flags,     // request flags byte
	input  wire logic [7:0]  req_cmd,       // command code
	input  wire logic [63:0] req_uid,       // uid field when present
	input  wire logic [15:0] req_block,     // (first) block index
	input  wire logic [7:0]  req_count,     // block count minus one
	input  wire logic [31:0] req_data,      // write data
	input  wire logic [63:0] own_uid,       // tag uid
	input  wire logic        wip_mode,      // 1 write-in-progress, 0 busy
	input  wire logic        sec_locked,    // sector of mem_addr locked
	input  wire logic [1:0]  sec_rw_prot,   // sector read/write protection
	input  wire logic [1:0]  sec_pwd_ctl,   // sector password control
	input  wire logic        sec_rd_denied, // read refused for that sector
	input  wire logic        sec_wr_denied, // write refused for that sector
	input  wire logic [31:0] mem_rd_data,   // block read data
	input  wire logic        mem_rd_valid,  // read data valid pulse
	input  wire logic        mem_wr_done,   // write and verify finished pulse
	input  wire logic        mem_wr_ok,     // verify passed, with done
	output var  logic        mem_rd_en,     // block read pulse
	output var  logic        mem_wr_en,     // block write pulse
	output var  logic [8:0]  mem_addr,      // block address
	output var  logic [31:0] mem_wr_data,   // block write data
	output var  logic        resp_valid,    // reply byte strobe
	output var  logic [7:0]  resp_byte,     // reply byte
	output var  logic        resp_last,     // last byte, crc follows
	output var  logic        selected,      // protocol state selected
	output var  logic        act_pin_o,     // activity pin level
	output var  logic        act_pin_oe     // activity pin drive enable
);
	rfbac_state_t st_r;
	logic [7:0]  cmd_r;
	logic        opt_r;
	logic        err_r;
	logic [7:0]  code_r;
	logic [4:0]  nblk_r;
	logic [1:0]  bidx_r;
	logic [31:0] rdata_r;
	logic [31:0] timer_r;
	logic        wr_done_r;
	logic        wr_ok_r;
	logic        mode_r;
	logic        busy_r;
	logic        run_r;
	logic [7:0]  flags_r;
	logic [63:0] uid_r;
	logic [15:0] block_r;
	logic [7:0]  count_r;
	logic        rf_rise;
	logic        push;
	logic [8:0]  push_word;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [8:0]  fifo_word;
	logic        pop;
	logic [16:0] last_blk;
	logic        uid_match;

	function automatic logic [7:0] sec_byte(input logic lk, input logic [1:0] rw,
			input logic [1:0] pw);
		return {3'b000, pw, rw, lk};
	endfunction

	function automatic logic is_read(input logic [7:0] c);
		return (c == RFBAC_CMD_READ_ONE) || (c == RFBAC_CMD_READ_MULTI);
	endfunction

	assign last_blk  = {1'b0, block_r} + {9'h000, count_r};
	assign uid_match = (uid_r == own_uid);

	rfbac_edge u_edge (
		.sys_clk (sys_clk),
		.srst    (srst),
		.pin_in  (rf_clk),
		.rise    (rf_rise)
	);

	// draining at link-clock pace lets the fifo fill and stall the reply builder
	assign pop = rf_rise & fifo_valid;

	rfbac_fifo #(
		.WIDTH (RFBAC_FIFO_WIDTH),
		.DEPTH (RFBAC_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_word),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_word)
	);

	// reply byte builder; word is {last, byte}
	always_comb begin
		push      = 1'b0;
		push_word = '0;
		case (st_r)
			ST_FLAGS: begin
				push      = fifo_ready;
				push_word = {!err_r && !is_read(cmd_r),
					err_r ? RFBAC_RESP_ERR : RFBAC_RESP_OK};
			end
			ST_ERRC: begin
				push      = fifo_ready;
				push_word = {1'b1, code_r};
			end
			ST_SEC: begin
				push      = fifo_ready;
				push_word = {1'b0, sec_byte(sec_locked, sec_rw_prot, sec_pwd_ctl)};
			end
			ST_DATA: begin
				push      = fifo_ready;
				push_word = {(bidx_r == 2'd3) && (nblk_r == '0),
					rdata_r[8*bidx_r +: 8]};
			end
			default: begin
				push      = 1'b0;
				push_word = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			resp_valid <= 1'b0;
			resp_byte  <= '0;
			resp_last  <= 1'b0;
		end else begin
			resp_valid <= pop;
			if (pop) begin
				resp_byte <= fifo_word[7:0];
				resp_last <= fifo_word[8];
			end
		end
	end

	// request capture and mode sampling
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_r  <= 1'b0;
			flags_r <= '0;
			cmd_r   <= '0;
			uid_r   <= '0;
			block_r <= '0;
			count_r <= '0;
		end else begin
			if (req_sof && st_r == ST_IDLE) begin
				mode_r <= wip_mode;
			end
			if (req_end && st_r == ST_IDLE) begin
				flags_r <= req_flags;
				cmd_r   <= req_cmd;
				uid_r   <= req_uid;
				block_r <= req_block;
				count_r <= req_count;
			end
		end
	end

	// command sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r        <= ST_IDLE;
			opt_r       <= 1'b0;
			err_r       <= 1'b0;
			code_r      <= '0;
			nblk_r      <= '0;
			bidx_r      <= '0;
			rdata_r     <= '0;
			timer_r     <= '0;
			wr_done_r   <= 1'b0;
			wr_ok_r     <= 1'b0;
			selected    <= 1'b0;
			mem_rd_en   <= 1'b0;
			mem_wr_en   <= 1'b0;
			mem_addr    <= '0;
			mem_wr_data <= '0;
		end else begin
			mem_rd_en <= 1'b0;
			mem_wr_en <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					if (req_end) begin
						if (req_crc_ok && req_fmt_ok) begin
							mem_wr_data <= req_data;
							st_r        <= ST_EVAL;
						end
					end
				end
				ST_EVAL: begin
					opt_r    <= flags_r[RFBAC_FLAG_OPTION];
					err_r    <= 1'b0;
					mem_addr <= block_r[8:0];
					nblk_r   <= count_r[4:0];
					bidx_r   <= '0;
					st_r     <= ST_CHK;
				end
				ST_CHK: begin
					st_r <= ST_FLAGS;
					if (cmd_r == RFBAC_CMD_SELECT) begin
						if (!uid_match) begin
							selected <= 1'b0;
							st_r     <= ST_IDLE;
						end else if (opt_r) begin
							err_r  <= 1'b1;
							code_r <= RFBAC_ERR_OPTION;
						end else begin
							selected <= 1'b1;
						end
					end else if (!(cmd_r == RFBAC_CMD_WRITE_ONE || is_read(cmd_r))) begin
						st_r <= ST_IDLE;
					end else if ((flags_r[RFBAC_FLAG_ADDRESS] && !uid_match)
							|| (flags_r[RFBAC_FLAG_SELECT] && !selected)) begin
						st_r <= ST_IDLE;
					end else if (!flags_r[RFBAC_FLAG_PROT_EXT]) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_GENERIC;
					end else if (block_r > RFBAC_LAST_BLOCK) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_NO_BLOCK;
					end else if (cmd_r == RFBAC_CMD_READ_MULTI
							&& last_blk > {1'b0, RFBAC_LAST_BLOCK}) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_NO_BLOCK;
					end else if (cmd_r == RFBAC_CMD_READ_MULTI
							&& (count_r > RFBAC_MAX_BLK_FLD
							|| last_blk[8:RFBAC_SECTOR_LSB]
							!= block_r[8:RFBAC_SECTOR_LSB])) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_GENERIC;
					end else if (is_read(cmd_r) && sec_rd_denied) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_RD_PROT;
					end else if (cmd_r == RFBAC_CMD_WRITE_ONE && sec_wr_denied) begin
						err_r  <= 1'b1;
						code_r <= RFBAC_ERR_LOCKED;
					end else if (cmd_r == RFBAC_CMD_WRITE_ONE) begin
						mem_wr_en <= 1'b1;
						timer_r   <= 32'(PROG_CYCLES);
						wr_done_r <= 1'b0;
						wr_ok_r   <= 1'b0;
						st_r      <= ST_PROG;
					end else if (cmd_r == RFBAC_CMD_READ_ONE) begin
						nblk_r <= '0;
					end
				end
				ST_PROG: begin
					if (timer_r != '0) begin
						timer_r <= timer_r - 32'd1;
					end
					if (mem_wr_done) begin
						wr_done_r <= 1'b1;
						wr_ok_r   <= mem_wr_ok;
					end
					// reply held until both the full cycle and the verify are over
					if (timer_r == '0 && wr_done_r) begin
						err_r  <= !wr_ok_r;
						code_r <= RFBAC_ERR_PROG_FAIL;
						st_r   <= ST_FLAGS;
					end
				end
				ST_FLAGS: begin
					if (fifo_ready) begin
						if (err_r) begin
							st_r <= ST_ERRC;
						end else if (is_read(cmd_r)) begin
							st_r <= ST_RDREQ;
						end else begin
							st_r <= ST_DRAIN;
						end
					end
				end
				ST_ERRC: begin
					if (fifo_ready) begin
						st_r <= ST_DRAIN;
					end
				end
				ST_RDREQ: begin
					mem_rd_en <= 1'b1;
					st_r      <= ST_RDWAIT;
				end
				ST_RDWAIT: begin
					if (mem_rd_valid) begin
						rdata_r <= mem_rd_data;
						st_r    <= opt_r ? ST_SEC : ST_DATA;
					end
				end
				ST_SEC: begin
					if (fifo_ready) begin
						st_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (fifo_ready) begin
						bidx_r <= bidx_r + 2'd1;
						if (bidx_r == 2'd3) begin
							if (nblk_r == '0) begin
								st_r <= ST_DRAIN;
							end else begin
								nblk_r   <= nblk_r - 5'd1;
								mem_addr <= mem_addr + 9'd1;
								st_r     <= ST_RDREQ;
							end
						end
					end
				end
				ST_DRAIN: begin
					if (!fifo_valid) begin
						st_r <= ST_IDLE;
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// activity pin, open drain: only ever pulls low
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_r     <= 1'b0;
			run_r      <= 1'b0;
			act_pin_o  <= 1'b0;
			act_pin_oe <= 1'b0;
		end else begin
			run_r <= (st_r != ST_IDLE);
			if (req_sof && st_r == ST_IDLE) begin
				busy_r <= 1'b1;
			end else if (st_r == ST_IDLE
					&& (run_r || (req_end && !(req_crc_ok && req_fmt_ok)))) begin
				busy_r <= 1'b0;
			end
			if (req_sof && st_r == ST_IDLE) begin
				act_pin_oe <= !wip_mode;
			end else if (mode_r) begin
				act_pin_oe <= (st_r == ST_PROG);
			end else begin
				act_pin_oe <= busy_r;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/rfbac_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module rfbac_checker
	import rfbac_pkg::*;
#(
	parameter int PROG_CYCLES = 20
) (
	input wire logic        sys_clk,    // clock
	input wire logic        srst,       // reset
	input wire logic        req_sof,    // frame start
	input wire logic        req_end,    // decoded
	input wire logic        req_crc_ok, // crc good
	input wire logic        req_fmt_ok, // format good
	input wire logic [7:0]  req_flags,  // flags
	input wire logic [7:0]  req_cmd,    // command
	input wire logic [63:0] req_uid,    // request uid
	input wire logic [63:0] own_uid,    // tag uid
	input wire logic        wip_mode,   // pin mode
	input wire logic        mem_rd_en,  // read pulse
	input wire logic        mem_wr_en,  // write pulse
	input wire logic        resp_valid, // reply strobe
	input wire logic        selected,   // selected
	input wire logic        act_pin_o,  // pin level
	input wire logic        act_pin_oe  // pin enable
);
	logic        wait_r;
	logic [31:0] cnt_r;
	logic        sel_c;
	assign sel_c = req_end && req_crc_ok && req_fmt_ok && req_cmd == RFBAC_CMD_SELECT;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// cycles since a block write was launched, until its reply shows
	always_ff @(posedge sys_clk) begin
		if (srst || resp_valid)
			wait_r <= 1'b0;
		else if (mem_wr_en)
			wait_r <= 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (mem_wr_en)
			cnt_r <= '0;
		else if (wait_r)
			cnt_r <= cnt_r + 32'h1;
	end
	a_pin_only_low: assert property (act_pin_oe |-> !act_pin_o)
		else $error("pin driven high");
	a_busy_at_sof: assert property (req_sof && !wip_mode |=> act_pin_oe)
		else $error("busy not shown after sof");
	a_busy_over_reply: assert property (resp_valid && !wip_mode |-> act_pin_oe)
		else $error("busy dropped during reply");
	a_wip_read_free: assert property (req_end && wip_mode && req_cmd != RFBAC_CMD_WRITE_ONE
		|=> (!act_pin_oe)[*8])
		else $error("pin driven on read in wip mode");
	a_wip_write_low: assert property (mem_wr_en && wip_mode |-> ##[0:2] act_pin_oe)
		else $error("pin not driven during program");
	a_wip_reply_free: assert property (resp_valid && wip_mode |-> !act_pin_oe)
		else $error("pin still driven in reply");
	a_prog_before_reply: assert property (resp_valid && wait_r |-> cnt_r >= PROG_CYCLES - 3)
		else $error("write reply before program time");
	a_drop_bad_req: assert property (req_end && !(req_crc_ok && req_fmt_ok)
		|=> (!mem_rd_en && !mem_wr_en && !resp_valid && $stable(selected))[*8])
		else $error("bad request acted on");
	a_select_own: assert property (sel_c && req_uid == own_uid && !req_flags[RFBAC_FLAG_OPTION]
		|-> ##[1:4] selected)
		else $error("select did not select");
	a_select_other: assert property (sel_c && req_uid != own_uid |-> ##[1:4] !selected)
		else $error("foreign select kept state");
	a_select_err_keep: assert property (sel_c && req_uid == own_uid && req_flags[RFBAC_FLAG_OPTION]
		|=> $stable(selected)[*6])
		else $error("select error changed state");
endmodule
`default_nettype wire

// [bench/rfbac_reader.sv]
`timescale 1ns/10ps
`default_nettype none
module rfbac_reader (
	input  wire logic       sys_clk,    // sampling clock
	input  wire logic       resp_valid, // reply strobe
	input  wire logic [7:0] resp_byte,  // reply byte
	input  wire logic       resp_last,  // final byte
	output var  logic       rf_clk      // link clock
);
	logic [8:0] got[$];
	// carrier stays unmodulated, so the clock never pauses, even in programming
	initial begin
		rf_clk = 1'b0;
		#5;
		forever #32 rf_clk = ~rf_clk;
	end
	always @(posedge sys_clk) begin
		if (resp_valid === 1'b1)
			got.push_back({resp_last, resp_byte});
	end
endmodule
`default_nettype wire

// [bench/test_rfbac_top.sv]
`timescale 1ns/10ps
`default_nettype none
module test_rfbac_top
	import rfbac_pkg::*;
;
	localparam int         PC = 20;
	localparam logic [7:0] PE = 8'h08; // reader sets protocol extension
	localparam logic [7:0] OP = 8'h40;
	localparam logic [7:0] RD = RFBAC_CMD_READ_ONE;
	localparam logic [7:0] RM = RFBAC_CMD_READ_MULTI;
	localparam logic [7:0] WR = RFBAC_CMD_WRITE_ONE;
	localparam logic [7:0] SL = RFBAC_CMD_SELECT;
	logic        sys_clk, srst, rf_clk, req_sof, req_end, req_crc_ok, req_fmt_ok, wip_mode;
	logic [7:0]  req_flags, req_cmd, req_count, resp_byte;
	logic [63:0] req_uid, own_uid;
	logic [15:0] req_block, seed;
	logic [31:0] req_data, mem_rd_data, mem_wr_data, wd;
	logic        sec_locked, sec_rd_denied, sec_wr_denied, mem_rd_valid, mem_wr_done, mem_wr_ok;
	logic [1:0]  sec_rw_prot, sec_pwd_ctl;
	logic        mem_rd_en, mem_wr_en, resp_valid, resp_last, selected, act_pin_o, act_pin_oe;
	logic [8:0]  mem_addr, rd_a, wr_a;
	logic [31:0] mem [512];
	logic [31:0] ref_m [512];
	logic [6:0]  sec_st [16];
	logic        rd_p, wr_fail, sel_m;
	logic [3:0]  wr_t;
	logic [8:0]  exp_q[$];
	int          n_fail, compares, cyc;
	rfbac_top #(.PROG_CYCLES(PC)) rfbac_top_i (.sys_clk, .srst, .rf_clk, .req_sof, .req_end,
		.req_crc_ok, .req_fmt_ok, .req_flags, .req_cmd, .req_uid, .req_block, .req_count,
		.req_data, .own_uid, .wip_mode, .sec_locked, .sec_rw_prot, .sec_pwd_ctl, .sec_rd_denied,
		.sec_wr_denied, .mem_rd_data, .mem_rd_valid, .mem_wr_done, .mem_wr_ok, .mem_rd_en,
		.mem_wr_en, .mem_addr, .mem_wr_data, .resp_valid, .resp_byte, .resp_last, .selected,
		.act_pin_o, .act_pin_oe);
	rfbac_reader rfbac_reader_i (.sys_clk, .resp_valid, .resp_byte, .resp_last, .rf_clk);
	// sector state packs {wr deny, rd deny, password, protection, lock}
	assign {sec_wr_denied, sec_rd_denied, sec_pwd_ctl, sec_rw_prot, sec_locked} = sec_st[mem_addr[8:5]];
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// memory answers reads two cycles late and verifies writes after seven
	always @(posedge sys_clk) begin
		rd_p <= mem_rd_en;
		mem_rd_valid <= rd_p;
		mem_wr_done <= (wr_t == 4'h1);
		mem_wr_ok <= !wr_fail;
		if (mem_rd_en)
			rd_a <= mem_addr;
		if (rd_p)
			mem_rd_data <= mem[rd_a];
		if (mem_wr_en) begin
			wr_t <= 4'h6;
			wr_a <= mem_addr;
			wd <= mem_wr_data;
		end else if (wr_t != 4'h0)
			wr_t <= wr_t - 4'h1;
		if (wr_t == 4'h1 && !wr_fail)
			mem[wr_a] <= wd;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad("timeout");
			tally_and_finish();
		end
	end
	task automatic bad(input string m);
		n_fail++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic err(input logic [7:0] c);
		exp_q.push_back({1'b0, RFBAC_RESP_ERR});
		exp_q.push_back({1'b1, c});
	endtask
	task automatic model(input logic [7:0] fl, c, input logic [15:0] b, input logic [7:0] n,
		input logic [31:0] d, input logic [63:0] u, input logic [1:0] ok);
		int         e;
		logic [6:0] s;
		exp_q.delete();
		if (c == RD)
			n = 8'h00;
		e = int'(b) + int'(n);
		s = sec_st[b[8:5]];
		if (ok != 2'b11)
			return;
		if (c == SL) begin
			if (u !== own_uid)
				sel_m = 1'b0;
			else if (fl[RFBAC_FLAG_OPTION])
				err(RFBAC_ERR_OPTION);
			else begin
				sel_m = 1'b1;
				exp_q.push_back({1'b1, RFBAC_RESP_OK});
			end
		end else if (fl[RFBAC_FLAG_ADDRESS] && u !== own_uid || fl[RFBAC_FLAG_SELECT] && !sel_m)
			return;
		else if (!fl[RFBAC_FLAG_PROT_EXT])
			err(RFBAC_ERR_GENERIC);
		else if (b > RFBAC_LAST_BLOCK || e > 511)
			err(RFBAC_ERR_NO_BLOCK);
		else if (c == WR) begin
			if (s[6])
				err(RFBAC_ERR_LOCKED);
			else if (wr_fail)
				err(RFBAC_ERR_PROG_FAIL);
			else begin
				ref_m[b[8:0]] = d;
				exp_q.push_back({1'b1, RFBAC_RESP_OK});
			end
		end else if (n > RFBAC_MAX_BLK_FLD || (e >> 5) != (int'(b) >> 5))
			err(RFBAC_ERR_GENERIC);
		else if (s[5])
			err(RFBAC_ERR_RD_PROT);
		else begin
			exp_q.push_back({1'b0, RFBAC_RESP_OK});
			for (int i = 0; i <= int'(n); i++) begin
				if (fl[RFBAC_FLAG_OPTION])
					exp_q.push_back({4'h0, s[4:0]});
				for (int k = 0; k < 4; k++)
					exp_q.push_back({1'b0, ref_m[int'(b) + i][8*k +: 8]});
			end
			exp_q[exp_q.size() - 1][8] = 1'b1;
		end
	endtask
	task automatic xact(input logic [7:0] fl, c, input logic [15:0] b, input logic [7:0] n,
		input logic [31:0] d, input logic [63:0] u, input logic [1:0] ok);
		int w;
		@(posedge sys_clk);
		model(fl, c, b, n, d, u, ok);
		req_sof <= 1'b1;
		req_flags <= fl;
		req_cmd <= c;
		req_block <= b;
		req_count <= n;
		req_data <= d;
		req_uid <= u;
		req_crc_ok <= ok[0];
		req_fmt_ok <= ok[1];
		@(posedge sys_clk);
		req_sof <= 1'b0;
		repeat (2) @(posedge sys_clk);
		req_end <= 1'b1;
		@(posedge sys_clk);
		req_end <= 1'b0;
		w = 0;
		while (w < (exp_q.size() > 0 ? 4000 : 300) && !(rfbac_reader_i.got.size() > 0
			&& rfbac_reader_i.got[rfbac_reader_i.got.size() - 1][8])) begin
			@(posedge sys_clk);
			w++;
		end
		repeat (4) @(posedge sys_clk);
		compares++;
		if (rfbac_reader_i.got.size() != exp_q.size())
			bad("reply length");
		else foreach (exp_q[i]) begin
			compares++;
			if (rfbac_reader_i.got[i] !== exp_q[i])
				bad("reply byte");
		end
		compares++;
		if (selected !== sel_m)
			bad("selected state");
		rfbac_reader_i.got.delete();
	endtask
	task automatic tally_and_finish();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		{srst, req_sof, req_end, req_crc_ok, req_fmt_ok, wip_mode, rd_p, wr_fail} = 8'h80;
		{req_flags, req_cmd, req_count, req_block, req_data, req_uid} = '0;
		{mem_rd_data, mem_rd_valid, mem_wr_done, mem_wr_ok, wr_t, sel_m, n_fail, compares, cyc} = '0;
		own_uid = 64'h5a3c_96e1_0f78_d24b;
		seed = 16'h0023;
		for (int i = 0; i < 512; i++) begin
			seed = lfsr(seed);
			mem[i] = {seed, ~seed};
			ref_m[i] = mem[i];
		end
		foreach (sec_st[i])
			sec_st[i] = 7'h00;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		sec_st[2] <= 7'h1b;
		sec_st[3] <= 7'h20;
		sec_st[1] <= 7'h16;
		sec_st[4] <= 7'h40;
		xact(PE, RD, 16'h0005, 8'h07, 0, 0, 3);
		xact(PE | OP, RD, 16'h0041, 0, 0, 0, 3);
		xact(8'h00, RD, 16'h0005, 0, 0, 0, 3);
		xact(PE, RD, 16'h0200, 0, 0, 0, 3);
		xact(PE, RD, 16'h0060, 0, 0, 0, 3);
		$display("single reads done");
		wip_mode <= 1'b1;
		xact(PE, WR, 16'h0123, 0, 32'hcafe_f00d, 0, 3);
		xact(PE, RD, 16'h0123, 0, 0, 0, 3);
		xact(PE, WR, 16'h0085, 0, 32'h1111_2222, 0, 3);
		wr_fail <= 1'b1;
		xact(PE, WR, 16'h0011, 0, 32'h3333_4444, 0, 3);
		wr_fail <= 1'b0;
		xact(PE, WR, 16'h0300, 0, 32'h5555_6666, 0, 3);
		xact(8'h00, WR, 16'h0012, 0, 32'h7777_8888, 0, 3);
		xact(PE, RD, 16'h0011, 0, 0, 0, 3);
		$display("writes done");
		wip_mode <= 1'b0;
		xact(PE, WR, 16'h0024, 0, 32'h9abc_def0, 0, 3);
		xact(PE | OP, RM, 16'h0020, 8'h1f, 0, 0, 3);
		xact(PE, RM, 16'h003e, 8'h02, 0, 0, 3);
		xact(PE, RM, 16'h0000, 8'h20, 0, 0, 3);
		xact(PE, RM, 16'h0200, 0, 0, 0, 3);
		xact(PE, RM, 16'h0061, 8'h03, 0, 0, 3);
		xact(8'h00, RM, 16'h0001, 8'h02, 0, 0, 3);
		$display("multi reads done");
		xact(OP, SL, 0, 0, 0, own_uid, 3);
		xact(8'h00, SL, 0, 0, 0, own_uid, 3);
		xact(PE | 8'h10, RD, 16'h0007, 0, 0, 0, 3);
		xact(OP, SL, 0, 0, 0, own_uid, 3);
		xact(8'h00, SL, 0, 0, 0, ~own_uid, 3);
		xact(PE | 8'h10, RD, 16'h0007, 0, 0, 0, 3);
		xact(PE | 8'h20, RD, 16'h0008, 0, 0, ~own_uid, 3);
		xact(PE | 8'h20, RD, 16'h0008, 0, 0, own_uid, 3);
		$display("select done");
		xact(PE, WR, 16'h0009, 0, 32'h1234_5678, 0, 2'b10);
		xact(PE, WR, 16'h0009, 0, 32'h1234_5678, 0, 2'b01);
		xact(8'h00, SL, 0, 0, 0, own_uid, 2'b10);
		xact(PE, RD, 16'h0009, 0, 0, 0, 3);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wip_mode <= seed[0];
			xact(PE | {1'b0, seed[1], 6'h0}, RD, {7'h0, seed[15:7]}, 0, 0, 0, 3);
		end
		$display("dropped and random done");
		tally_and_finish();
	end
endmodule
bind rfbac_top rfbac_checker #(.PROG_CYCLES(PROG_CYCLES)) rfbac_checker_i (.sys_clk, .srst,
	.req_sof, .req_end, .req_crc_ok, .req_fmt_ok, .req_flags, .req_cmd, .req_uid, .own_uid,
	.wip_mode, .mem_rd_en, .mem_wr_en, .resp_valid, .selected, .act_pin_o, .act_pin_oe);
`default_nettype wire
